// file: rtl/cae_err_report.v
// Error checking and reporting for the scratchpad, tick compare, trap stack and MMU register arrays.
//
// Notes on behaviour
// (RL1) Each array class is checked only while its own recording enable bit is set.
// (RL2) Diagnostic reads and writes never check, record or trap.
// (RL3) Correctable scratchpad read returns uncorrected data and leaves the array unchanged.
// (RL4) Correctable scratchpad error with precise enable logs code, index, syndrome and traps.
// (RL5) Uncorrectable scratchpad error with precise enable logs code, index and traps.
// (RL6) With precise enable clear, precise errors are neither logged nor trapped.
// (RL7) Normal stores write fresh check bits computed from the written data.
// (RL8) Tick compare entries are swept in turn against the running tick counters.
// (RL9) Correctable tick read with precise enable logs code, index, syndrome and traps.
// (RL10) Uncorrectable tick read with precise enable logs code, index, syndrome and traps.
// (RL11) Compare sweep error suppresses that compare and logs disrupting status regardless.
// (RL12) Logged disrupting error traps when enabled and interrupts qualify.
// (RL13) A disrupting error logged while disabled traps once software enables it.
// (RL14) Trap stack is checked on reads, done or retry, and read-modify-write writes.
// (RL15) Unused trap stack bits count as zero for check bit generation and checking.
// (RL16) Trap stack correctable error corrects nothing and suppresses a pending write.
// (RL17) Trap stack correctable error with precise enable logs code, index, syndrome, traps.
// (RL18) Trap stack uncorrectable error with precise enable logs code, index and traps.
// (RL19) MMU array parity checked on normal reads, writes and walks when enabled.
// (RL20) MMU array parity error on a normal read or write flags the trap unit and suppresses a normal write.
// (RL21) MMU array error on a normal read or write with precise enable logs code, index and traps precisely.
// (RL22) MMU array parity error during a walk gives the matching translation fault.
// (RL23) No trap is ever raised for an error that was not recorded.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cae_err_defs.vh"

module cae_err_report #(
  parameter TSA_USED_MASK = 32'h0FFFFFFF
) (
  input wire core_clk_in,
  input wire rst_in,
  input wire [7:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire acc_valid_in,
  input wire [1:0] acc_array_in,
  input wire [2:0] acc_kind_in,
  input wire [`CAE_IW-1:0] acc_index_in,
  input wire [`CAE_DW-1:0] acc_wdata_in,
  input wire [`CAE_CW-1:0] acc_wcheck_in,
  output reg rsp_valid_out,
  output reg [`CAE_DW-1:0] rsp_rdata_out,
  output reg [`CAE_CW-1:0] rsp_check_out,
  output reg internal_fault_trap_out,
  output reg mmu_array_error_out,
  output reg fetch_translation_fault_trap_out,
  output reg load_store_translation_fault_trap_out,
  input wire interrupt_enable_flag_in,
  input wire hyperprivileged_flag_in,
  input wire [`CAE_DW-1:0] tick_count_in,
  input wire [`CAE_DW-1:0] stick_count_in,
  output reg [2:0] tick_match_out,
  output reg disrupting_recoverable_trap_out
);

  // ****************************************************************
  // Check bit and byte merge functions
  // ****************************************************************
  function [`CAE_CW-1:0] cae_ecc_gen;
    input [`CAE_DW-1:0] d;
    integer pos;
    integer i;
    integer k;
    reg [5:0] c;
    begin
      c = 6'h00;
      i = 0;
      for (pos = 3; pos < 39; pos = pos + 1) begin
        if ((pos & (pos - 1)) != 0) begin
          for (k = 0; k < 6; k = k + 1) begin
            if (((pos >> k) & 1) == 1) begin
              c[k] = c[k] ^ d[i];
            end
          end
          i = i + 1;
        end
      end
      cae_ecc_gen = {^{d, c}, c};
    end
  endfunction

  function [`CAE_DW-1:0] cae_byte_merge;
    input [`CAE_DW-1:0] old;
    input [`CAE_DW-1:0] wd;
    input [3:0] be;
    integer b;
    begin
      cae_byte_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (be[b]) begin
          cae_byte_merge[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // Storage and control registers
  // ****************************************************************
  reg [`CAE_EW-1:0] mem_reg [0:31];
  reg [`CAE_REC_W-1:0] rec_en_reg;
  reg [`CAE_TEN_W-1:0] trap_en_reg;
  reg [`CAE_CODE_W-1:0] dfstat_reg;
  reg [31:0] dfaddr_reg;
  reg des_f_reg;
  reg des_me_reg;
  reg [`CAE_CODE_W-1:0] des_code_reg;
  reg [`CAE_IW-1:0] des_idx_reg;
  reg [1:0] sweep_reg;
  reg [1:0] sweep_next;

  // ****************************************************************
  // Access checking
  // ****************************************************************
  wire [`CAE_MW-1:0] acc_addr = {acc_array_in, acc_index_in};
  wire [`CAE_EW-1:0] acc_ent = mem_reg[acc_addr];
  wire is_tsa = (acc_array_in == `CAE_ARR_TSTACK);
  wire is_mra = (acc_array_in == `CAE_ARR_MMU);
  wire [`CAE_DW-1:0] acc_data = acc_ent[`CAE_DW-1:0];
  wire [`CAE_DW-1:0] acc_chk_data = is_tsa ? (acc_data & TSA_USED_MASK) : acc_data; // RL15
  wire [`CAE_CW-1:0] acc_gen = cae_ecc_gen(acc_chk_data);
  wire acc_par = ^{acc_chk_data, acc_ent[`CAE_EW-1:`CAE_DW]};
  wire [`CAE_CW-1:0] acc_syn = {acc_par, acc_gen[`CAE_CW-2:0] ^ acc_ent[`CAE_EW-2:`CAE_DW]};
  wire acc_ce = acc_syn[`CAE_CW-1];
  wire acc_ue = ~acc_syn[`CAE_CW-1] & (acc_syn[`CAE_CW-2:0] != 6'h00);
  wire acc_pe = ^{acc_data, acc_ent[`CAE_DW]};
  wire kind_rd = (acc_kind_in == `CAE_KIND_RD);
  wire kind_wr = (acc_kind_in == `CAE_KIND_WR);
  wire kind_dr = (acc_kind_in == `CAE_KIND_DONE_RETRY);
  wire kind_walk = (acc_kind_in == `CAE_KIND_WALK_FETCH) | (acc_kind_in == `CAE_KIND_WALK_DATA);
  wire kind_diag = (acc_kind_in == `CAE_KIND_DIAG_RD) | (acc_kind_in == `CAE_KIND_DIAG_WR);
  wire pscce = trap_en_reg[`CAE_TEN_PSCCE];

  reg chk_ce;
  reg chk_ue;
  reg [`CAE_CODE_W-1:0] chk_code;
  reg chk_wsup;
  reg chk_mra;
  reg chk_walk;
  always @* begin
    chk_ce = 1'b0;
    chk_ue = 1'b0;
    chk_code = `CAE_CODE_NONE;
    chk_wsup = 1'b0;
    chk_mra = 1'b0;
    chk_walk = 1'b0;
    if (acc_valid_in && !kind_diag) begin // RL2
      case (acc_array_in)
        `CAE_ARR_SCRATCH: begin
          if (kind_rd) begin
            chk_ce = acc_ce & rec_en_reg[`CAE_REC_SCAC]; // RL1
            chk_ue = acc_ue & rec_en_reg[`CAE_REC_SCAU]; // RL1
            chk_code = chk_ue ? `CAE_CODE_SCAU : `CAE_CODE_SCAC;
          end
        end
        `CAE_ARR_TICK: begin
          if (kind_rd) begin
            chk_ce = acc_ce & rec_en_reg[`CAE_REC_TCCP]; // RL1
            chk_ue = acc_ue & rec_en_reg[`CAE_REC_TCUP]; // RL1
            chk_code = chk_ue ? `CAE_CODE_TCUP : `CAE_CODE_TCCP;
          end
        end
        `CAE_ARR_TSTACK: begin
          if (kind_rd || kind_wr || kind_dr) begin // RL14
            chk_ce = acc_ce & rec_en_reg[`CAE_REC_TSAC]; // RL1
            chk_ue = acc_ue & rec_en_reg[`CAE_REC_TSAU]; // RL1
            chk_code = chk_ue ? `CAE_CODE_TSAU : `CAE_CODE_TSAC;
            chk_wsup = kind_wr & (chk_ce | chk_ue); // RL16
          end
        end
        default: begin
          if (kind_rd || kind_wr) begin
            chk_mra = acc_pe & rec_en_reg[`CAE_REC_MRAU]; // RL19
            chk_code = `CAE_CODE_MRAU;
            chk_wsup = kind_wr & chk_mra; // RL20
          end else if (kind_walk) begin
            chk_walk = acc_pe & rec_en_reg[`CAE_REC_MRAU]; // RL19
          end
        end
      endcase
    end
  end

  wire chk_err = chk_ce | chk_ue | chk_mra;
  wire take_precise = chk_err & pscce; // RL6 RL23

  // ****************************************************************
  // Tick compare sweep
  // ****************************************************************
  wire [`CAE_MW-1:0] swp_addr = {`CAE_ARR_TICK, 1'b0, sweep_reg};
  wire [`CAE_EW-1:0] swp_ent = mem_reg[swp_addr];
  wire [`CAE_DW-1:0] swp_data = swp_ent[`CAE_DW-1:0];
  wire [`CAE_CW-1:0] swp_gen = cae_ecc_gen(swp_data);
  wire swp_par = ^{swp_data, swp_ent[`CAE_EW-1:`CAE_DW]};
  wire [`CAE_CW-1:0] swp_syn = {swp_par, swp_gen[`CAE_CW-2:0] ^ swp_ent[`CAE_EW-2:`CAE_DW]};
  wire swp_ce = swp_syn[`CAE_CW-1] & rec_en_reg[`CAE_REC_TCCD]; // RL1
  wire swp_ue = ~swp_syn[`CAE_CW-1] & (swp_syn[`CAE_CW-2:0] != 6'h00) & rec_en_reg[`CAE_REC_TCUD]; // RL1
  wire swp_err = swp_ce | swp_ue;
  wire [`CAE_DW-1:0] swp_count = (sweep_reg == 2'h0) ? tick_count_in : stick_count_in;
  wire swp_hit = (swp_data == swp_count) & ~swp_err; // RL11

  always @* begin
    if (sweep_reg == `CAE_TICK_LAST) begin // RL8
      sweep_next = 2'h0;
    end else begin
      sweep_next = sweep_reg + 2'h1;
    end
  end

  // ****************************************************************
  // Per-entry match pulses
  // ****************************************************************
  wire [`CAE_TICK_ENTRIES-1:0] swp_hit_vec;
  genvar ent_g;
  generate
    for (ent_g = 0; ent_g < `CAE_TICK_ENTRIES; ent_g = ent_g + 1) begin : g_tick_hit
      localparam [1:0] ENT_SEL = ent_g;
      assign swp_hit_vec[ent_g] = swp_hit & (sweep_reg == ENT_SEL); // RL8 RL11
    end
  endgenerate

  // ****************************************************************
  // Array update, access answer and sweep step
  // ****************************************************************
  wire [`CAE_DW-1:0] wr_data = is_tsa ? (acc_wdata_in & TSA_USED_MASK) : acc_wdata_in; // RL15
  wire [`CAE_CW-1:0] wr_check = is_mra ? {6'h00, ^acc_wdata_in} : cae_ecc_gen(wr_data);

  always @(posedge core_clk_in) begin
    if (acc_valid_in) begin
      if (kind_wr && !chk_wsup) begin
        mem_reg[acc_addr] <= {wr_check, wr_data}; // RL7 RL16 RL20
      end else if (acc_kind_in == `CAE_KIND_DIAG_WR) begin
        mem_reg[acc_addr] <= {acc_wcheck_in, acc_wdata_in}; // RL2
      end
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 32'h00000000;
      rsp_check_out <= 7'h00;
      tick_match_out <= 3'h0;
      sweep_reg <= 2'h0;
    end else begin
      rsp_valid_out <= acc_valid_in & ~kind_wr & (acc_kind_in != `CAE_KIND_DIAG_WR);
      rsp_rdata_out <= acc_data; // RL3 RL6
      rsp_check_out <= acc_ent[`CAE_EW-1:`CAE_DW];
      tick_match_out <= swp_hit_vec; // RL8 RL11
      sweep_reg <= sweep_next;
    end
  end

  // ****************************************************************
  // Precise and translation trap outputs
  // ****************************************************************
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      internal_fault_trap_out <= 1'b0;
      mmu_array_error_out <= 1'b0;
      fetch_translation_fault_trap_out <= 1'b0;
      load_store_translation_fault_trap_out <= 1'b0;
    end else begin
      internal_fault_trap_out <= take_precise; // RL4 RL5 RL9 RL10 RL17 RL18 RL21
      mmu_array_error_out <= chk_mra; // RL20
      fetch_translation_fault_trap_out <= chk_walk & (acc_kind_in == `CAE_KIND_WALK_FETCH); // RL22
      load_store_translation_fault_trap_out <= chk_walk & (acc_kind_in == `CAE_KIND_WALK_DATA); // RL22
    end
  end

  // ****************************************************************
  // Register bus slave
  // ****************************************************************
  wire bus_req = avs_read_in | avs_write_in;
  wire bus_wr = avs_write_in & ~avs_waitrequest_out;
  wire [31:0] des_word = {des_f_reg, des_me_reg, 19'h00000, des_idx_reg, 4'h0, des_code_reg};
  reg [31:0] rd_mux;
  always @* begin
    case (avs_address_in)
      `CAE_OFF_REC_EN: rd_mux = {23'h000000, rec_en_reg};
      `CAE_OFF_TRAP_EN: rd_mux = {30'h00000000, trap_en_reg};
      `CAE_OFF_DFSTAT: rd_mux = {28'h0000000, dfstat_reg};
      `CAE_OFF_DFADDR: rd_mux = dfaddr_reg;
      `CAE_OFF_DESTAT: rd_mux = des_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire [31:0] rec_merged = cae_byte_merge({23'h000000, rec_en_reg}, avs_writedata_in, avs_byteenable_in);
  wire [31:0] ten_merged = cae_byte_merge({30'h00000000, trap_en_reg}, avs_writedata_in, avs_byteenable_in);

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h00000000;
      rec_en_reg <= `CAE_REC_RESET;
      trap_en_reg <= `CAE_TEN_RESET;
    end else begin
      avs_waitrequest_out <= ~(bus_req & avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) begin
        avs_readdata_out <= rd_mux;
      end
      if (bus_wr && avs_address_in == `CAE_OFF_REC_EN) begin
        rec_en_reg <= rec_merged[`CAE_REC_W-1:0]; // RL1
      end
      if (bus_wr && avs_address_in == `CAE_OFF_TRAP_EN) begin
        trap_en_reg <= ten_merged[`CAE_TEN_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Fault logging; hardware setting wins over a software clear
  // ****************************************************************
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      dfstat_reg <= `CAE_CODE_NONE;
      dfaddr_reg <= 32'h00000000;
    end else if (take_precise) begin
      dfstat_reg <= chk_code; // RL4 RL5 RL9 RL10 RL17 RL18 RL21
      dfaddr_reg <= 32'h00000000;
      dfaddr_reg[`CAE_IW-1:0] <= acc_index_in;
      dfaddr_reg[`CAE_DFA_SYN_LSB +: `CAE_CW] <= chk_mra ? 7'h00 : acc_syn; // RL4 RL9 RL10 RL17
    end else if (bus_wr && avs_address_in == `CAE_OFF_DFSTAT) begin
      dfstat_reg <= `CAE_CODE_NONE;
    end else if (bus_wr && avs_address_in == `CAE_OFF_DFADDR) begin
      dfaddr_reg <= 32'h00000000;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      des_f_reg <= 1'b0;
      des_me_reg <= 1'b0;
      des_code_reg <= `CAE_CODE_NONE;
      des_idx_reg <= 3'h0;
    end else if (swp_err) begin
      if (!des_f_reg) begin
        des_f_reg <= 1'b1; // RL11
        des_code_reg <= swp_ue ? `CAE_CODE_TCUD : `CAE_CODE_TCCD; // RL11
        des_idx_reg <= {1'b0, sweep_reg}; // RL11
      end else begin
        des_me_reg <= 1'b1;
      end
    end else if (bus_wr && avs_address_in == `CAE_OFF_DESTAT) begin
      des_f_reg <= 1'b0;
      des_me_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Disrupting trap presentation
  // ****************************************************************
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      disrupting_recoverable_trap_out <= 1'b0;
    end else begin
      disrupting_recoverable_trap_out <= des_f_reg & trap_en_reg[`CAE_TEN_DE] &
        (interrupt_enable_flag_in | ~hyperprivileged_flag_in); // RL12 RL13 RL23
    end
  end

endmodule

// file: rtl/cae_err_defs.vh
// Constants for the core array error checking and reporting block.
`ifndef CAE_ERR_DEFS_VH
`define CAE_ERR_DEFS_VH

// ****************************************************************
// Data, check and index widths
// ****************************************************************
`define CAE_DW 32
`define CAE_CW 7
`define CAE_EW 39
`define CAE_IW 3
`define CAE_MW 5
`define CAE_CODE_W 4

// ****************************************************************
// Array selectors and access kinds
// ****************************************************************
`define CAE_ARR_SCRATCH 2'h0
`define CAE_ARR_TICK 2'h1
`define CAE_ARR_TSTACK 2'h2
`define CAE_ARR_MMU 2'h3
`define CAE_KIND_RD 3'h0
`define CAE_KIND_WR 3'h1
`define CAE_KIND_DIAG_RD 3'h2
`define CAE_KIND_DIAG_WR 3'h3
`define CAE_KIND_DONE_RETRY 3'h4
`define CAE_KIND_WALK_FETCH 3'h5
`define CAE_KIND_WALK_DATA 3'h6
`define CAE_TICK_ENTRIES 2'h3
`define CAE_TICK_LAST 2'h2

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CAE_OFF_REC_EN 8'h00
`define CAE_OFF_TRAP_EN 8'h04
`define CAE_OFF_DFSTAT 8'h08
`define CAE_OFF_DFADDR 8'h0C
`define CAE_OFF_DESTAT 8'h10

// ****************************************************************
// Recording enable fields
// ****************************************************************
`define CAE_REC_W 9
`define CAE_REC_SCAC 0
`define CAE_REC_SCAU 1
`define CAE_REC_TCCP 2
`define CAE_REC_TCUP 3
`define CAE_REC_TCCD 4
`define CAE_REC_TCUD 5
`define CAE_REC_TSAC 6
`define CAE_REC_TSAU 7
`define CAE_REC_MRAU 8
`define CAE_REC_RESET 9'h000

// ****************************************************************
// Trap enable fields
// ****************************************************************
`define CAE_TEN_W 2
`define CAE_TEN_PSCCE 0
`define CAE_TEN_DE 1
`define CAE_TEN_RESET 2'h0

// ****************************************************************
// Fault address and disrupting status layout
// ****************************************************************
`define CAE_DFA_SYN_LSB 8
`define CAE_DES_IDX_LSB 8
`define CAE_DES_ME 30
`define CAE_DES_F 31

// ****************************************************************
// Error codes
// ****************************************************************
`define CAE_CODE_NONE 4'h0
`define CAE_CODE_SCAC 4'h1
`define CAE_CODE_SCAU 4'h2
`define CAE_CODE_TCCP 4'h3
`define CAE_CODE_TCUP 4'h4
`define CAE_CODE_TSAC 4'h5
`define CAE_CODE_TSAU 4'h6
`define CAE_CODE_MRAU 4'h7
`define CAE_CODE_TCCD 4'h8
`define CAE_CODE_TCUD 4'h9

`endif

// file: tb/cae_err_report_asserts.sv
// Port assertions for the array error reporting block.
`timescale 1ns/1ps
module cae_err_report_asserts (
  input wire core_clk_in,
  input wire rst_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire avs_waitrequest_out,
  input wire acc_valid_in,
  input wire [1:0] acc_array_in,
  input wire [2:0] acc_kind_in,
  input wire rsp_valid_out,
  input wire internal_fault_trap_out,
  input wire mmu_array_error_out,
  input wire fetch_translation_fault_trap_out,
  input wire load_store_translation_fault_trap_out,
  input wire interrupt_enable_flag_in,
  input wire hyperprivileged_flag_in,
  input wire disrupting_recoverable_trap_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  a_bus_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("bus answer too long");
  a_diag_quiet: assert property (acc_valid_in && acc_kind_in[2:1] == 2'h1 |=> !(internal_fault_trap_out ||
    mmu_array_error_out || fetch_translation_fault_trap_out || load_store_translation_fault_trap_out))
    else $error("diagnostic access flagged");
  a_rsp_follow: assert property (acc_valid_in && acc_kind_in != 3'h1 && acc_kind_in != 3'h3 |=> rsp_valid_out)
    else $error("read answer missing");
  a_trap_cause: assert property (internal_fault_trap_out |-> $past(acc_valid_in) && $past(acc_kind_in) != 3'h2 &&
    $past(acc_kind_in) != 3'h3) else $error("trap without access");
  a_walk_fetch: assert property (fetch_translation_fault_trap_out |-> $past(acc_valid_in) &&
    $past(acc_array_in) == 2'h3 && $past(acc_kind_in) == 3'h5) else $error("fetch fault without walk");
  a_walk_data: assert property (load_store_translation_fault_trap_out |-> $past(acc_valid_in) &&
    $past(acc_array_in) == 2'h3 && $past(acc_kind_in) == 3'h6) else $error("data fault without walk");
  a_mmu_source: assert property (mmu_array_error_out |-> $past(acc_valid_in) &&
    $past(acc_array_in) == 2'h3 && $past(acc_kind_in) <= 3'h1) else $error("mmu error without access");
  a_dis_qual: assert property (disrupting_recoverable_trap_out |->
    $past(interrupt_enable_flag_in) || !$past(hyperprivileged_flag_in)) else $error("disrupting trap unqualified");
endmodule

// file: tb/cae_tick_src.sv
// Running tick and system tick counters seen by the compare sweep.
`timescale 1ns/1ps
module cae_tick_src (
  input wire core_clk_in,
  input wire rst_in,
  input wire run_in,
  output reg [31:0] tick_count_out,
  output reg [31:0] stick_count_out
);
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      tick_count_out <= 32'h0;
      stick_count_out <= 32'h0;
    end else if (run_in) begin
      tick_count_out <= tick_count_out + 32'h1;
      stick_count_out <= stick_count_out + 32'h1;
    end
  end
endmodule

// file: tb/cae_err_report_tb_top.sv
// Self-checking bench for the array error reporting block.
`timescale 1ns/1ps
module cae_err_report_tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd_r = 1'b0;
  logic wr_r = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hF;
  logic av = 1'b0;
  logic [1:0] aa = 2'h0;
  logic [2:0] ak = 3'h0;
  logic [2:0] ai = 3'h0;
  logic [31:0] ad = 32'h0;
  logic [6:0] ac = 7'h00;
  logic ie = 1'b0;
  logic hp = 1'b0;
  logic run = 1'b0;
  wire [31:0] rdata, tick, stick, r_d;
  wire wreq, r_v, t_if, t_mmu, t_f, t_ls, t_dis;
  wire [6:0] r_c;
  wire [2:0] tm;
  logic [3:0] hit;
  logic [31:0] q;
  logic [2:0] m;
  int fail_count = 0;
  int check_count = 0;
  cae_tick_src u_src (.core_clk_in(core_clk_in), .rst_in(rst_in), .run_in(run), .tick_count_out(tick),
    .stick_count_out(stick));
  cae_err_report DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd_r),
    .avs_write_in(wr_r), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .acc_valid_in(av), .acc_array_in(aa), .acc_kind_in(ak), .acc_index_in(ai),
    .acc_wdata_in(ad), .acc_wcheck_in(ac), .rsp_valid_out(r_v), .rsp_rdata_out(r_d), .rsp_check_out(r_c),
    .internal_fault_trap_out(t_if), .mmu_array_error_out(t_mmu), .fetch_translation_fault_trap_out(t_f),
    .load_store_translation_fault_trap_out(t_ls), .interrupt_enable_flag_in(ie),
    .hyperprivileged_flag_in(hp), .tick_count_in(tick), .stick_count_in(stick), .tick_match_out(tm),
    .disrupting_recoverable_trap_out(t_dis));
  initial begin
    forever #10 core_clk_in = ~core_clk_in;
  end
  task close_out;
    if (fail_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge core_clk_in);
    adr <= a;
    wd <= d;
    be <= b;
    rd_r <= !w;
    wr_r <= w;
    @(posedge core_clk_in);
    while (wreq !== 1'b0 && n < 20) begin
      n++;
      @(posedge core_clk_in);
    end
    q = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    if (n == 20) begin
      fail_count++;
      $display("BAD %0t bus timeout", $time);
      close_out;
    end
  endtask
  task acc(input logic [1:0] a, input logic [2:0] k, input logic [2:0] i, input logic [31:0] d,
    input logic [6:0] c);
    @(posedge core_clk_in);
    av <= 1'b1;
    aa <= a;
    ak <= k;
    ai <= i;
    ad <= d;
    ac <= c;
    @(posedge core_clk_in);
    av <= 1'b0;
    #1;
    hit = {t_f, t_ls, t_mmu, t_if};
  endtask
  task prec(input logic [1:0] a, input logic [2:0] k, input logic [2:0] i, input logic [31:0] d,
    input logic [3:0] h, input logic [3:0] code);
    acc(a, 3'h3, i, d, 7'h00);
    bus(1'b1, 8'h08, 32'h0, 4'hF);
    acc(a, k, i, 32'h5A, 7'h00);
    cmp(32'(hit), 32'(h));
    if (k != 3'h1) cmp(r_d, d);
    cmp(32'(r_v), 32'(k != 3'h1));
    bus(1'b0, 8'h08, 32'h0, 4'hF);
    cmp(32'(q[3:0]), 32'(code));
    if (code != 4'h0) begin
      bus(1'b0, 8'h0C, 32'h0, 4'hF);
      cmp(32'(q[2:0]), 32'(i));
    end
  endtask
  task t_regs;
    for (int a = 0; a <= 32; a += 4) begin
      bus(1'b0, 8'(a), 32'h0, 4'hF);
      cmp(q, 32'h0);
    end
    bus(1'b1, 8'h00, 32'hFFFFFFFF, 4'hF);
    bus(1'b1, 8'h00, 32'h0, 4'h2);
    bus(1'b0, 8'h00, 32'h0, 4'hF);
    cmp(q, 32'h000000FF);
    bus(1'b1, 8'h04, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, 8'h04, 32'h0, 4'hF);
    cmp(q, 32'h00000003);
  endtask
  task t_precise;
    bus(1'b1, 8'h00, 32'h000001CF, 4'hF);
    bus(1'b1, 8'h04, 32'h00000001, 4'hF);
    prec(2'h0, 3'h0, 3'h2, 32'h1, 4'h1, 4'h1);
    bus(1'b0, 8'h0C, 32'h0, 4'hF);
    cmp(q, 32'h00004302);
    prec(2'h0, 3'h0, 3'h5, 32'h3, 4'h1, 4'h2);
    prec(2'h1, 3'h0, 3'h1, 32'h1, 4'h1, 4'h3);
    prec(2'h1, 3'h0, 3'h2, 32'h3, 4'h1, 4'h4);
    prec(2'h2, 3'h1, 3'h3, 32'h1, 4'h1, 4'h5);
    acc(2'h2, 3'h2, 3'h3, 32'h0, 7'h00);
    cmp(r_d, 32'h1);
    prec(2'h2, 3'h4, 3'h4, 32'h3, 4'h1, 4'h6);
    prec(2'h3, 3'h1, 3'h1, 32'h1, 4'h3, 4'h7);
    acc(2'h3, 3'h2, 3'h1, 32'h0, 7'h00);
    cmp(r_d, 32'h1);
    prec(2'h3, 3'h0, 3'h6, 32'h1, 4'h3, 4'h7);
    prec(2'h3, 3'h5, 3'h1, 32'h1, 4'h8, 4'h0);
    prec(2'h3, 3'h6, 3'h1, 32'h1, 4'h4, 4'h0);
    prec(2'h0, 3'h2, 3'h2, 32'h1, 4'h0, 4'h0);
  endtask
  task t_masks;
    bus(1'b1, 8'h04, 32'h0, 4'hF);
    prec(2'h0, 3'h0, 3'h2, 32'h1, 4'h0, 4'h0);
    prec(2'h3, 3'h0, 3'h1, 32'h1, 4'h2, 4'h0);
    bus(1'b1, 8'h04, 32'h1, 4'hF);
    bus(1'b1, 8'h00, 32'h0, 4'hF);
    prec(2'h0, 3'h0, 3'h2, 32'h1, 4'h0, 4'h0);
    prec(2'h3, 3'h5, 3'h1, 32'h1, 4'h0, 4'h0);
  endtask
  task t_store;
    bus(1'b1, 8'h00, 32'h000001CF, 4'hF);
    acc(2'h0, 3'h1, 3'h2, 32'h1, 7'h00);
    acc(2'h0, 3'h0, 3'h2, 32'h0, 7'h00);
    cmp(32'(hit), 32'h0);
    cmp(r_d, 32'h1);
    cmp(32'(r_c), 32'h43);
    acc(2'h2, 3'h3, 3'h6, 32'h0, 7'h00);
    acc(2'h2, 3'h1, 3'h6, 32'hF0000001, 7'h00);
    acc(2'h2, 3'h0, 3'h6, 32'h0, 7'h00);
    cmp(32'(hit), 32'h0);
    cmp(r_d, 32'h1);
    cmp(32'(r_c), 32'h43);
  endtask
  task t_sweep;
    bus(1'b1, 8'h00, 32'h0, 4'hF);
    for (int e = 0; e < 3; e++) acc(2'h1, 3'h3, 3'(e), 32'h0, (e == 1) ? 7'h01 : 7'h00);
    bus(1'b1, 8'h00, 32'h000001FF, 4'hF);
    @(posedge core_clk_in);
    m = 3'h0;
    repeat (6) begin
      @(posedge core_clk_in);
      m = m | tm;
    end
    cmp(32'(m), 32'h5);
    bus(1'b0, 8'h10, 32'h0, 4'hF);
    cmp(q, 32'hC0000108);
    cmp(32'(t_dis), 32'h0);
    hp <= 1'b1;
    ie <= 1'b1;
    bus(1'b1, 8'h04, 32'h3, 4'hF);
    repeat (2) @(posedge core_clk_in);
    #1 cmp(32'(t_dis), 32'h1);
    @(posedge core_clk_in);
    ie <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 cmp(32'(t_dis), 32'h0);
    @(posedge core_clk_in);
    hp <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    #1 cmp(32'(t_dis), 32'h1);
    acc(2'h1, 3'h3, 3'h1, 32'h0, 7'h00);
    bus(1'b1, 8'h10, 32'h0, 4'hF);
    repeat (2) @(posedge core_clk_in);
    #1 cmp(32'(t_dis), 32'h0);
    @(posedge core_clk_in);
    run <= 1'b1;
  endtask
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_precise;
    t_masks;
    t_store;
    t_sweep;
    repeat (4) @(posedge core_clk_in);
    close_out;
  end
endmodule
bind cae_err_report cae_err_report_asserts u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .acc_valid_in(acc_valid_in), .acc_array_in(acc_array_in), .acc_kind_in(acc_kind_in),
  .rsp_valid_out(rsp_valid_out), .internal_fault_trap_out(internal_fault_trap_out),
  .mmu_array_error_out(mmu_array_error_out), .fetch_translation_fault_trap_out(fetch_translation_fault_trap_out),
  .load_store_translation_fault_trap_out(load_store_translation_fault_trap_out),
  .interrupt_enable_flag_in(interrupt_enable_flag_in), .hyperprivileged_flag_in(hyperprivileged_flag_in),
  .disrupting_recoverable_trap_out(disrupting_recoverable_trap_out));
